/* dv/mfm_disk_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Disk side: one MFM cell per oscillator cycle, each pulse one cycle wide
module mfm_disk_model (
   // Cell clock
   input  wire logic       clk,
   // Pattern: 0 quiet, 1 zeroes preamble, 2 bad spacing, 3 one mark byte then zeroes
   input  wire logic [1:0] mode,
   // Encoded pulse line
   output var  logic       mfm
);
   logic prev;
   logic marked;

   // Quiet line rests low
   initial begin
      mfm    = 1'b0;
      prev   = 1'b0;
      marked = 1'b0;
   end

   // Clock cell first, then data cell; miss drops one clock bit
   task automatic send_byte(input logic [7:0] b, input int miss);
      for (int i = 7; i >= 0; i--) begin
         @(posedge clk) mfm <= !(prev | b[i]) && (i != miss);
         @(posedge clk) mfm <= b[i];
         prev = b[i];
      end
   endtask

   // Pattern loop; the mark goes out once per entry into mode 3
   always begin
      if (mode == 2'h3 && !marked) begin
         marked = 1'b1;
         send_byte(8'ha1, 2); // Clock of bit two absent, framed by present clocks
      end else if (mode == 2'h2) begin
         // Three-cycle spacing never forms a valid preamble
         @(posedge clk) mfm <= 1'b1;
         repeat (2) @(posedge clk) mfm <= 1'b0;
      end else if (mode != 2'h0) begin
         send_byte(8'h00, -1);
      end else begin
         @(posedge clk) mfm <= 1'b0;
      end
      if (mode != 2'h3) marked = 1'b0;
   end
endmodule // mfm_disk_model
`default_nettype wire

/* dv/tb_mfm_read_sync_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_mfm_read_sync_decoder;
   import mfm_pkg::*;
   logic        pclk             = 1'b0;
   logic        presetn          = 1'b0;
   logic [11:0] paddr            = 12'h000;
   logic        psel             = 1'b0;
   logic        penable          = 1'b0;
   logic        pwrite           = 1'b0;
   logic [31:0] pwdata           = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        oscillator_clock = 1'b0;
   logic        ref_clk          = 1'b0;
   logic        mfm_in;
   logic [1:0]  mode             = 2'h0;
   link_out_t   link_out;
   wire logic   lock_apply_n;
   int          err_count        = 0;
   int          n_checks         = 0;
   int          rises            = 0;
   int          miss_seen        = 0;
   int          nrz_ones         = 0;
   logic        rc_seen          = 1'b0;
   logic        flag_nrz         = 1'b0;

   // Normal use: lock output drives lock apply
   assign lock_apply_n = link_out.preamble_found_n;

   // Clocks: bus 40 ns, link 6 ns, reference 24 ns
   always #20 pclk = ~pclk;
   always #3 oscillator_clock = ~oscillator_clock;
   always #12 ref_clk = ~ref_clk;

   mfm_read_sync_decoder mfm_read_sync_decoder_inst (
      .pclk                        (pclk),
      .presetn                     (presetn),
      .paddr                       (paddr),
      .psel                        (psel),
      .penable                     (penable),
      .pwrite                      (pwrite),
      .pwdata                      (pwdata),
      .prdata                      (prdata),
      .pready                      (pready),
      .pslverr                     (pslverr),
      .oscillator_clock            (oscillator_clock),
      .reference_double_rate_clock (ref_clk),
      .mfm_in                      (mfm_in),
      .lock_apply_n                (lock_apply_n),
      .link_out                    (link_out)
   );

   mfm_disk_model mfm_disk_model_inst (
      .clk  (oscillator_clock),
      .mode (mode),
      .mfm  (mfm_in)
   );

   // sample on rises
   // Outputs launch with the read clock rise, so take them one oscillator edge later to avoid a race
   always @(posedge oscillator_clock) begin
      rc_seen <= link_out.read_clock;
      if (link_out.read_clock === 1'b1 && rc_seen === 1'b0) begin
         rises++;
         if (link_out.preamble_found_n === 1'b0 && link_out.missing_clock === 1'b1) begin
            miss_seen++;
            flag_nrz = link_out.nrz_data;
         end
         if (link_out.preamble_found_n === 1'b0 && link_out.nrz_data === 1'b1 && mode == 2'h1) nrz_ones++;
      end
   end

   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // Single exit of the run
   task automatic give_verdict();
      if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      int k;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         err_count++;
         $display("wrong value at %0t: bus answer timed out", $time);
         give_verdict();
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(a, 1'b1, d, r, e);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic e_exp, input string what);
      logic [31:0] r;
      logic        e;
      apb(a, 1'b0, 32'h0, r, e);
      check(r, exp, what);
      check({31'h0, e}, {31'h0, e_exp}, "slave error");
   endtask

   // Lock waits are bounded; a hang ends the run as a failure
   task automatic wait_found(input logic lvl);
      int k;
      k = 0;
      while (link_out.preamble_found_n !== lvl && k < 400) begin
         @(posedge pclk);
         k++;
      end
      if (k == 400) begin
         err_count++;
         $display("wrong value at %0t: lock wait timed out", $time);
         give_verdict();
      end
   endtask

   // Main sequence
   initial begin
      int base;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, read-only status, unmapped space
      rd_chk(ADDR_CTRL, 32'h0, 1'b0, "ctrl reset");
      rd_chk(ADDR_MISS_CNT, 32'h0, 1'b0, "miss reset");
      wr(ADDR_STATUS, 32'h7);
      rd_chk(ADDR_STATUS, 32'h0, 1'b0, "status reset");
      rd_chk(12'h00c, 32'h0, 1'b1, "unmapped");
      // Wrong pulse spacing keeps restarting the hunt
      mode <= 2'h2;
      wr(ADDR_CTRL, 32'h3);
      repeat (100) @(posedge pclk);
      rd_chk(ADDR_STATUS, 32'h1, 1'b0, "hunting");
      // Proper preamble locks and hands the read clock to the oscillator
      mode <= 2'h1;
      wait_found(1'b0);
      repeat (4) @(posedge pclk);
      rd_chk(ADDR_STATUS, 32'h7, 1'b0, "locked");
      @(negedge oscillator_clock);
      base = rises;
      repeat (40) @(negedge oscillator_clock);
      check(32'(rises - base), 32'd20, "read clock rate");
      check(32'(nrz_ones), 32'h0, "preamble data");
      // One mark byte gives exactly one flag
      mode <= 2'h3;
      repeat (20) @(posedge pclk);
      rd_chk(ADDR_MISS_CNT, 32'h1, 1'b0, "miss count");
      check(32'(miss_seen), 32'h1, "flags seen");
      check(32'(flag_nrz), 32'h1, "flag with last bit");
      // Dropping read enable aborts quickly and returns to idle
      wr(ADDR_CTRL, 32'h0);
      @(posedge pclk);
      check({29'h0, link_out.nrz_data, link_out.missing_clock, link_out.preamble_found_n}, 32'h1, "abort");
      repeat (4) @(posedge pclk);
      rd_chk(ADDR_STATUS, 32'h0, 1'b0, "idle status");
      // Entry wait: sixteen read clock rises, or one when bypassed
      mode <= 2'h1;
      for (int b = 0; b < 2; b++) begin
         wr(ADDR_CTRL, 32'h0);
         repeat (10) @(posedge pclk);
         wr(ADDR_CTRL, (b == 1) ? 32'h3 : 32'h1);
         base = rises;
         wait_found(1'b0);
         check(32'((rises - base) >= ((b == 1) ? 1 : 16) && (rises - base) <= ((b == 1) ? 10 : 26)),
               32'h1, "entry wait");
      end
      give_verdict();
   end
endmodule // tb_mfm_read_sync_decoder
`default_nettype wire

/* rtl/mfm_pkg.sv */
package mfm_pkg;

   // Register byte addresses on the APB window
   localparam logic [11:0] ADDR_CTRL      = 12'h000;
   localparam logic [11:0] ADDR_STATUS    = 12'h004;
   localparam logic [11:0] ADDR_MISS_CNT  = 12'h008;

   // Control register fields
   localparam int          CTRL_RD_EN_BIT  = 0;
   localparam int          CTRL_BYPASS_BIT = 1;
   localparam logic [1:0]  CTRL_RESET      = 2'h0;

   // Status register field positions
   localparam int          STAT_READING_BIT = 0;
   localparam int          STAT_LOCKED_BIT  = 1;
   localparam int          STAT_SRC_OSC_BIT = 2;

   // Entry wait, counted in read clock rising edges
   localparam logic [4:0]  ENTRY_WAIT_EDGES   = 5'h10;
   localparam logic [4:0]  ENTRY_BYPASS_EDGES = 5'h01;

   // Lock detection: pulses needed and their spacing in oscillator cycles
   localparam logic [4:0]  LOCK_PULSES   = 5'h10;
   localparam logic [1:0]  PULSE_SPACING = 2'h2;

   // Widths
   localparam int          MISS_CNT_W = 16;

   typedef enum logic [1:0] {ST_IDLE, ST_ENTRY, ST_HUNT, ST_LOCKED} rd_state_t;

   // Controller-facing link outputs
   typedef struct packed {
      logic read_clock;
      logic nrz_data;
      logic missing_clock;
      logic preamble_found_n;
   } link_out_t;

   // Status carried from the oscillator domain to the bus domain
   typedef struct packed {
      logic miss_toggle;
      logic src_osc;
      logic locked;
      logic reading;
   } link_stat_t;

endpackage

/* rtl/mfm_read_sync_decoder.sv */
// Contract
// - Bypass low: lock hunt after 16 edges
// - Bypass high: lock hunt after one edge
// - NRZ bit out two to three periods later
// - Decode latency fixed once locked
// - Encoded input reaches output in 1-3 edges
// - Read enable low aborts within two periods
// - Changeover holds read clock low briefly
// - Flag missing clock framed by present clocks
// - Output may lag one oscillator period
// - Undelayed: flag aligned with final bit
// - Delayed: flag one period before final bit
// - Bit period equals two oscillator periods
// - Lock-apply low selects oscillator, enables decoder
// - Sixteen spaced pulses declare lock, else restart
// - Read enable low returns everything idle
// - Zeroes preamble keeps NRZ low
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mfm_read_sync_decoder (
   // APB slave
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic [11:0]         paddr,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [31:0]         pwdata,
   output var  logic [31:0]         prdata,
   output var  logic                pready,
   output var  logic                pslverr,
   // Link side clocks and inputs
   input  wire logic                oscillator_clock,
   input  wire logic                reference_double_rate_clock,
   input  wire logic                mfm_in,
   input  wire logic                lock_apply_n,
   // Link side outputs
   output var  mfm_pkg::link_out_t  link_out
);
   import mfm_pkg::*;

   logic [1:0]            ctrl_q;
   logic [MISS_CNT_W-1:0] miss_cnt_q;
   logic                  miss_prev_q;
   link_stat_t            stat_s;
   link_stat_t            stat_o;
   logic                  osc_rst_n;
   logic                  s_rd_en, s_bypass, s_ref, s_mfm, s_lock_n;
   logic                  ref_prev_q, mfm_prev_q;
   logic                  ref_rise, pulse;
   rd_state_t             state_q, state_d;
   logic [4:0]            entry_cnt_q, entry_last;
   logic [4:0]            pre_cnt_q;
   logic [1:0]            gap_q;
   logic                  rc_q, rc_d, src_q, src_d, rc_rise;
   logic                  want_osc, clk_cell, data_cell, dec_en;
   logic [1:0]            c_hist_q, d_hist_q;
   logic                  d_stage_q, data_seen_q, miss_tgl_q;
   logic [2:0]            miss_pend_q;
   logic                  go_idle, miss_hit;

   // Bus domain

   // Ready is high during the first access cycle, so every transfer takes one wait-free access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~(paddr == ADDR_CTRL || paddr == ADDR_STATUS || paddr == ADDR_MISS_CNT);
         if (psel && !penable) begin
            unique case (paddr)
               ADDR_CTRL:     prdata <= {30'h0, ctrl_q};
               ADDR_STATUS:   prdata <= {29'h0, stat_o.src_osc, stat_o.locked, stat_o.reading};
               ADDR_MISS_CNT: prdata <= {16'h0, miss_cnt_q};
               default:       prdata <= 32'h0;
            endcase
         end
      end
   end

   // Control register: read enable and entry-wait bypass
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RESET;
      end else if (psel && penable && pready && pwrite && paddr == ADDR_CTRL) begin
         ctrl_q <= pwdata[1:0];
      end
   end

   // Missing clock events arrive as toggles; the counter wraps, software takes differences
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         miss_prev_q <= 1'b0;
         miss_cnt_q  <= '0;
      end else begin
         miss_prev_q <= stat_o.miss_toggle;
         if (stat_o.miss_toggle != miss_prev_q) begin
            miss_cnt_q <= miss_cnt_q + 16'h1;
         end
      end
   end

   // Status levels cross into the bus domain
   assign stat_s = '{miss_toggle: miss_tgl_q, src_osc: src_q,
                     locked: ~link_out.preamble_found_n, reading: state_q != ST_IDLE};
   mfm_sync_2ff #(.W(4)) u_stat_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     (stat_s),
      .q     (stat_o)
   );

   // Oscillator domain

   // Reset release is retimed to the oscillator clock
   mfm_sync_2ff #(.W(1)) u_rst_sync (
      .clk   (oscillator_clock),
      .rst_n (presetn),
      .d     (1'b1),
      .q     (osc_rst_n)
   );

   // Control bits, pins and the reference clock all pass two flops first
   mfm_sync_2ff #(.W(5)) u_link_sync (
      .clk   (oscillator_clock),
      .rst_n (osc_rst_n),
      .d     ({ctrl_q[CTRL_RD_EN_BIT], ctrl_q[CTRL_BYPASS_BIT], reference_double_rate_clock, mfm_in, lock_apply_n}),
      .q     ({s_rd_en, s_bypass, s_ref, s_mfm, s_lock_n})
   );

   // Edge detectors read the synchronised stage only
   always_ff @(posedge oscillator_clock or negedge osc_rst_n) begin
      if (!osc_rst_n) begin
         ref_prev_q <= 1'b0;
         mfm_prev_q <= 1'b0;
      end else begin
         ref_prev_q <= s_ref;
         mfm_prev_q <= s_mfm;
      end
   end
   assign ref_rise = s_ref & ~ref_prev_q;
   assign pulse    = s_mfm & ~mfm_prev_q;

   assign entry_last = s_bypass ? (ENTRY_BYPASS_EDGES - 5'h1) : (ENTRY_WAIT_EDGES - 5'h1);
   assign go_idle    = ~s_rd_en;
   assign want_osc   = (state_q == ST_LOCKED) & ~s_lock_n;

   // Read sequencing
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE:   if (s_rd_en) state_d = ST_ENTRY;
         ST_ENTRY:  if (rc_rise && entry_cnt_q == entry_last) state_d = ST_HUNT;
         ST_HUNT:   if (pulse && gap_q == PULSE_SPACING - 2'h1 && pre_cnt_q == LOCK_PULSES - 5'h1) state_d = ST_LOCKED;
         ST_LOCKED: state_d = ST_LOCKED;
      endcase
      if (go_idle) begin
         state_d = ST_IDLE;
      end
   end

   always_ff @(posedge oscillator_clock or negedge osc_rst_n) begin
      if (!osc_rst_n) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // count read clock rises during entry
   always_ff @(posedge oscillator_clock or negedge osc_rst_n) begin
      if (!osc_rst_n) begin
         entry_cnt_q <= 5'h0;
      end else if (state_q != ST_ENTRY) begin
         entry_cnt_q <= 5'h0;
      end else if (rc_rise) begin
         entry_cnt_q <= entry_cnt_q + 5'h1;
      end
   end

   // spacing check; any gap or early pulse restarts the count
   always_ff @(posedge oscillator_clock or negedge osc_rst_n) begin
      if (!osc_rst_n) begin
         gap_q     <= 2'h3;
         pre_cnt_q <= 5'h0;
      end else if (state_q != ST_HUNT) begin
         gap_q     <= 2'h3;
         pre_cnt_q <= 5'h0;
      end else if (pulse) begin
         gap_q     <= 2'h0;
         pre_cnt_q <= (gap_q == PULSE_SPACING - 2'h1) ? pre_cnt_q + 5'h1 : 5'h1;
      end else begin
         gap_q <= (gap_q == 2'h3) ? gap_q : gap_q + 2'h1;
         if (gap_q == PULSE_SPACING - 2'h1) begin
            pre_cnt_q <= 5'h0;
         end
      end
   end

   // Read clock source mux; the source only changes with the clock low or on the edge that takes it low, so no runt pulse
   always_comb begin
      src_d = src_q;
      rc_d  = rc_q;
      if (!src_q) begin
         // switch in a low phase on a clock-cell pulse
         if (want_osc && pulse && !rc_q) begin
            src_d = 1'b1;
         end else if (ref_rise) begin
            rc_d = ~rc_q;
         end
      end else begin
         rc_d = ~rc_q;
         // fall back to the reference on the edge that takes the clock low
         if (!want_osc && rc_q) begin
            src_d = 1'b0;
         end
      end
   end
   assign rc_rise = rc_d & ~rc_q;

   always_ff @(posedge oscillator_clock or negedge osc_rst_n) begin
      if (!osc_rst_n) begin
         rc_q  <= 1'b0;
         src_q <= 1'b0;
      end else begin
         rc_q  <= rc_d;
         src_q <= src_d;
      end
   end

   // Cell phase is fixed at changeover: the first oscillator-mode cycle is a data cell.
   // phase chosen so output is never delayed
   assign dec_en    = src_q & want_osc;
   assign clk_cell  = dec_en & rc_q;
   assign data_cell = dec_en & ~rc_q;
   // absent clock framed by present clocks, data zero
   assign miss_hit  = clk_cell & pulse & c_hist_q[1] & ~c_hist_q[0] & ~d_hist_q[1] & ~d_hist_q[0];

   always_ff @(posedge oscillator_clock or negedge osc_rst_n) begin
      if (!osc_rst_n) begin
         c_hist_q    <= 2'h0;
         d_hist_q    <= 2'h0;
         d_stage_q   <= 1'b0;
         miss_pend_q <= 3'h0;
         data_seen_q <= 1'b0;
         miss_tgl_q  <= 1'b0;
      end else if (!dec_en) begin
         c_hist_q    <= 2'h0;
         d_hist_q    <= 2'h0;
         d_stage_q   <= 1'b0;
         miss_pend_q <= 3'h0;
         data_seen_q <= 1'b0;
      end else if (clk_cell) begin
         c_hist_q    <= {c_hist_q[0], pulse};
         miss_pend_q <= {miss_pend_q[1:0], miss_hit}; // Waits two bits so the flag meets the byte's last bit
         if (miss_hit) begin
            miss_tgl_q <= ~miss_tgl_q;
         end
      end else begin
         d_hist_q  <= {d_hist_q[0], pulse};
         d_stage_q <= pulse;
         // preamble ends at first data one
         if (pulse) begin
            data_seen_q <= 1'b1;
         end
      end
   end

   // Registered link outputs; NRZ and flag update on data cells so they move with read clock rises
   always_ff @(posedge oscillator_clock or negedge osc_rst_n) begin
      if (!osc_rst_n) begin
         link_out <= '{read_clock: 1'b0, nrz_data: 1'b0, missing_clock: 1'b0, preamble_found_n: 1'b1};
      end else begin
         link_out.read_clock <= rc_d;
         link_out.preamble_found_n <= ~(state_d == ST_LOCKED);
         if (go_idle || !dec_en) begin
            link_out.nrz_data      <= 1'b0;
            link_out.missing_clock <= 1'b0;
         end else if (data_cell) begin
            link_out.nrz_data      <= d_stage_q & data_seen_q;
            // flag issued with the last data bit
            link_out.missing_clock <= miss_pend_q[2];
         end
      end
   end

   // Checks on the oscillator side, plus the bus handshake
   sequence s_switch_low;
      !link_out.read_clock ##1 link_out.read_clock;
   endsequence

   a_entry_wait_len: assert property (@(posedge oscillator_clock) disable iff (!osc_rst_n)
      (state_q == ST_ENTRY && state_d == ST_HUNT && !s_bypass) |-> entry_cnt_q == 5'h0f)
      else $error("Entry wait not sixteen edges");
   a_entry_bypass: assert property (@(posedge oscillator_clock) disable iff (!osc_rst_n)
      (state_q == ST_ENTRY && state_d == ST_HUNT && s_bypass) |-> entry_cnt_q == 5'h00)
      else $error("Bypass entry not one edge");
   a_abort_time: assert property (@(posedge oscillator_clock) disable iff (!osc_rst_n)
      (!s_rd_en && state_q != ST_IDLE) |=> state_q == ST_IDLE ##1 link_out.preamble_found_n)
      else $error("Read abort too slow");
   a_half_rate: assert property (@(posedge oscillator_clock) disable iff (!osc_rst_n)
      (src_q && $past(src_q)) |-> link_out.read_clock != $past(link_out.read_clock))
      else $error("Read clock not half oscillator rate");
   a_switch_hold: assert property (@(posedge oscillator_clock) disable iff (!osc_rst_n)
      $rose(src_q) |-> s_switch_low)
      else $error("Changeover held read clock wrong");
   a_lock_count: assert property (@(posedge oscillator_clock) disable iff (!osc_rst_n)
      (state_q == ST_HUNT && state_d == ST_LOCKED) |-> pre_cnt_q == 5'h0f && gap_q == 2'h1)
      else $error("Lock declared without sixteen pulses");
   a_missing_width: assert property (@(posedge oscillator_clock) disable iff (!osc_rst_n)
      ($rose(link_out.missing_clock) && dec_en && $past(dec_en)) |-> ##1 link_out.missing_clock ##1 !link_out.missing_clock)
      else $error("Missing clock flag not one bit period");
   a_nrz_on_rise: assert property (@(posedge oscillator_clock) disable iff (!osc_rst_n)
      (dec_en && $past(dec_en) && $changed(link_out.nrz_data)) |-> $rose(link_out.read_clock))
      else $error("NRZ moved off a read clock rise");
   a_quiet_unlocked: assert property (@(posedge oscillator_clock) disable iff (!osc_rst_n)
      (!src_q && !$past(src_q)) |-> !link_out.nrz_data && !link_out.missing_clock)
      else $error("Decoder active before lock applied");
   a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready ##1 !pready)
      else $error("APB ready not one cycle");

endmodule // mfm_read_sync_decoder
`default_nettype wire

/* rtl/mfm_sync_2ff.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-stage level synchroniser; only the second stage is visible outside
module mfm_sync_2ff #(
   parameter int W = 1
) (
   // Destination clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Data
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   // First stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule // mfm_sync_2ff
`default_nettype wire
